/* File: verilog/ccr_core_config_map.svh */
// addresses, field positions and reset values of the core configuration registers
`ifndef CCR_CORE_CONFIG_MAP_SVH
`define CCR_CORE_CONFIG_MAP_SVH

// ----------------------------------------------------------------------------
// register addressing in the system coprocessor space
// ----------------------------------------------------------------------------
`define CCR_REG_NUM        5'h10
`define CCR_SEL_PRIMARY    3'h0
`define CCR_SEL_SECONDARY  3'h1

// ----------------------------------------------------------------------------
// primary word fields
// ----------------------------------------------------------------------------
`define CCR_BIT_MORE       31
`define CCR_UPPER_LSB      28
`define CCR_USER_LSB       25
`define CCR_KSEG0_LSB      0
`define CCR_CCA_RESET      3'h2
`define CCR_BIT_CUSTOM     22
`define CCR_BIT_SBE        21
`define CCR_BIT_MDU        20
`define CCR_BIT_DSRAM      16
`define CCR_BIT_ENDIAN     15
`define CCR_AT_LSB         13
`define CCR_AT_VAL         2'h0
`define CCR_AR_LSB         10
`define CCR_AR_VAL         3'h1
`define CCR_MT_LSB         7
`define CCR_MT_VAL         3'h3
`define CCR_PRI_RSVD_MASK  32'h018E0078
`define CCR_PRI_FIXED_MASK 32'h81FFFFF8
`define CCR_PRI_FIXED_VAL  32'h80210580

// ----------------------------------------------------------------------------
// secondary word fields
// ----------------------------------------------------------------------------
`define CCR_BIT_PERF       4
`define CCR_BIT_WATCH      3
`define CCR_BIT_COMPRESS   2
`define CCR_BIT_DEBUG      1
`define CCR_BIT_FLOAT      0
`define CCR_SEC_WORD       32'h80000012

`endif

/* File: verilog/ccr_pkg.sv */
// types shared by the core configuration register bank
package ccr_pkg;

	typedef logic [2:0] ccr_cca_t;

	typedef enum logic [1:0] {
		CCR_TGT_NONE,
		CCR_TGT_PRIMARY,
		CCR_TGT_SECONDARY
	} ccr_target_t;

endpackage

/* File: verilog/ccr_cca_field.sv */
// one software-writable three-bit cacheability field
`timescale 1ns/1ns
`include "ccr_core_config_map.svh"

module ccr_cca_field
(
	input  logic             sys_clk,
	input  logic             resetn,
	input  logic             wr_en,
	input  ccr_pkg::ccr_cca_t wr_value,
	output ccr_pkg::ccr_cca_t value
);
	import ccr_pkg::*;

	ccr_cca_t next_value;

	always_comb
	begin
		next_value = value;
		if (wr_en)
			next_value = wr_value;
	end

	// reset value reports that no cache is fitted
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			value <= `CCR_CCA_RESET;
		else
			value <= next_value;
	end

endmodule

/* File: verilog/ccr_word_build.sv */
// assembles the read value of the addressed configuration word
`timescale 1ns/1ns
`include "ccr_core_config_map.svh"

module ccr_word_build
(
	input  ccr_pkg::ccr_target_t target,
	input  ccr_pkg::ccr_cca_t    upper,
	input  ccr_pkg::ccr_cca_t    user,
	input  ccr_pkg::ccr_cca_t    kseg0,
	output logic [31:0]          word
);
	import ccr_pkg::*;

	// unlisted bits stay zero, so reserved groups read back clear
	always_comb
	begin
		word = 32'h00000000;
		unique case (target)
			CCR_TGT_PRIMARY:
			begin
				word[`CCR_BIT_MORE]         = 1'b1;
				word[`CCR_UPPER_LSB +: 3]   = upper;
				word[`CCR_USER_LSB +: 3]    = user;
				word[`CCR_BIT_CUSTOM]       = 1'b0;
				word[`CCR_BIT_SBE]          = 1'b1;
				word[`CCR_BIT_MDU]          = 1'b0;
				word[`CCR_BIT_DSRAM]        = 1'b1;
				word[`CCR_BIT_ENDIAN]       = 1'b0;
				word[`CCR_AT_LSB +: 2]      = `CCR_AT_VAL;
				word[`CCR_AR_LSB +: 3]      = `CCR_AR_VAL;
				word[`CCR_MT_LSB +: 3]      = `CCR_MT_VAL;
				word[`CCR_KSEG0_LSB +: 3]   = kseg0;
			end
			CCR_TGT_SECONDARY:
			begin
				word[`CCR_BIT_MORE]         = 1'b1;
				word[`CCR_BIT_PERF]         = 1'b1;
				word[`CCR_BIT_WATCH]        = 1'b0;
				word[`CCR_BIT_COMPRESS]     = 1'b0;
				word[`CCR_BIT_DEBUG]        = 1'b1;
				word[`CCR_BIT_FLOAT]        = 1'b0;
			end
			CCR_TGT_NONE:
			begin
				word = 32'h00000000;
			end
		endcase
	end

endmodule

/* File: verilog/ccr_core_config.sv */
// core configuration register bank: primary and secondary configuration words
//
// What this block does
// - words live at register 16, select 0 and 1
// - primary bit 31 always reads one
// - upper kernel cacheability writable, resets to 010
// - user segment cacheability writable, resets to 010
// - kernel segment 0 coherency writable, resets 010
// - reserved primary groups read zero, written zero
// - custom instruction bit reads zero
// - simple byte enable bit reads one
// - multiply/divide type bit reads zero
// - dual sram bit reads one
// - endian zero, arch type 00, revision 001
// - memory management type reads 011
// - secondary bit 31 one, bits 30-5 zero
// - secondary perf counter bit reads one
// - secondary debug extension bit reads one
// - secondary bits 3, 2, 0 read zero
`timescale 1ns/1ns
`include "ccr_core_config_map.svh"

module ccr_core_config
(
	input  logic              sys_clk,
	input  logic              resetn,
	input  logic [4:0]        cop_reg_num,
	input  logic [2:0]        cop_sel,
	input  logic              cop_rd_en,
	input  logic              cop_wr_en,
	input  logic [31:0]       cop_wdata,
	output logic [31:0]       cop_rdata,
	output logic              cop_rd_valid,
	output logic              cop_hit,
	output logic              wr_ignored,
	output logic              reserved_wr_error,
	output ccr_pkg::ccr_cca_t upper_kseg_cacheability,
	output ccr_pkg::ccr_cca_t user_seg_cacheability,
	output ccr_pkg::ccr_cca_t kernel_seg0_coherency
);
	import ccr_pkg::*;

	// ------------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------------
	function automatic ccr_target_t ccr_decode(input logic [4:0] num, input logic [2:0] sel);
		ccr_target_t tgt;
		tgt = CCR_TGT_NONE;
		if (num == `CCR_REG_NUM && sel == `CCR_SEL_PRIMARY)
			tgt = CCR_TGT_PRIMARY;
		else if (num == `CCR_REG_NUM && sel == `CCR_SEL_SECONDARY)
			tgt = CCR_TGT_SECONDARY;
		return tgt;
	endfunction

	ccr_target_t rd_target;
	ccr_target_t wr_target;
	logic        pri_wr;
	logic [31:0] rd_word;

	assign rd_target = ccr_decode(cop_reg_num, cop_sel);
	assign wr_target = ccr_decode(cop_reg_num, cop_sel);
	assign pri_wr    = cop_wr_en && (wr_target == CCR_TGT_PRIMARY);

	// ------------------------------------------------------------------------
	// writable cacheability fields
	// ------------------------------------------------------------------------
	// only these three groups take write data; every other bit is hardwired,
	// so a write to any other bit of either word has no storage to land in
	ccr_cca_t cca_q [3];

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_cca
			localparam int LSB = (gi == 0) ? `CCR_UPPER_LSB :
			                     (gi == 1) ? `CCR_USER_LSB : `CCR_KSEG0_LSB;
			ccr_cca_field u_field
			(
				.sys_clk  (sys_clk),
				.resetn   (resetn),
				.wr_en    (pri_wr),
				.wr_value (cop_wdata[LSB +: 3]),
				.value    (cca_q[gi])
			);
		end
	endgenerate

	assign upper_kseg_cacheability = cca_q[0];
	assign user_seg_cacheability   = cca_q[1];
	assign kernel_seg0_coherency   = cca_q[2];

	// ------------------------------------------------------------------------
	// read data assembly
	// ------------------------------------------------------------------------
	ccr_word_build u_build
	(
		.target (rd_target),
		.upper  (cca_q[0]),
		.user   (cca_q[1]),
		.kseg0  (cca_q[2]),
		.word   (rd_word)
	);

	// ------------------------------------------------------------------------
	// response registers
	// ------------------------------------------------------------------------
	logic [31:0] next_cop_rdata;
	logic        next_cop_rd_valid;
	logic        next_cop_hit;
	logic        next_wr_ignored;
	logic        next_reserved_wr_error;

	// a read in the same cycle as a write returns the value before the write
	always_comb
	begin
		next_cop_rdata         = cop_rdata;
		next_cop_rd_valid      = cop_rd_en;
		next_cop_hit           = 1'b0;
		next_wr_ignored        = 1'b0;
		next_reserved_wr_error = 1'b0;
		if (cop_rd_en)
		begin
			next_cop_rdata = rd_word;
			next_cop_hit   = (rd_target != CCR_TGT_NONE);
		end
		else if (cop_wr_en)
			next_cop_hit = (wr_target != CCR_TGT_NONE);
		if (cop_wr_en && wr_target != CCR_TGT_PRIMARY)
			next_wr_ignored = 1'b1;
		// software owes zeros here; a nonzero write is flagged, never stored
		if (pri_wr && (cop_wdata & `CCR_PRI_RSVD_MASK) != 32'h00000000)
			next_reserved_wr_error = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cop_rdata         <= 32'h00000000;
			cop_rd_valid      <= 1'b0;
			cop_hit           <= 1'b0;
			wr_ignored        <= 1'b0;
			reserved_wr_error <= 1'b0;
		end
		else
		begin
			cop_rdata         <= next_cop_rdata;
			cop_rd_valid      <= next_cop_rd_valid;
			cop_hit           <= next_cop_hit;
			wr_ignored        <= next_wr_ignored;
			reserved_wr_error <= next_reserved_wr_error;
		end
	end

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	// checks pause in reset, so $past just after release can still see values sampled during reset

	logic rd_pri;
	logic rd_sec;
	assign rd_pri = cop_rd_en && cop_reg_num == `CCR_REG_NUM && cop_sel == `CCR_SEL_PRIMARY;
	assign rd_sec = cop_rd_en && cop_reg_num == `CCR_REG_NUM && cop_sel == `CCR_SEL_SECONDARY;

	sequence s_rd_pri;
		rd_pri ##1 cop_rd_valid;
	endsequence

	AST_MAP_HIT: assert property (
		cop_rd_en |=> cop_rd_valid && (cop_hit == ($past(rd_pri) || $past(rd_sec))))
		else $error("hit does not match register 16 select 0 or 1");

	AST_MORE_PRIMARY: assert property (
		s_rd_pri |-> cop_rdata[`CCR_BIT_MORE] == 1'b1)
		else $error("primary bit 31 not set");

	AST_UPPER_WRITE: assert property (
		(cop_wr_en && cop_reg_num == `CCR_REG_NUM && cop_sel == `CCR_SEL_PRIMARY)
		|=> upper_kseg_cacheability == $past(cop_wdata[`CCR_UPPER_LSB +: 3]))
		else $error("upper kernel cacheability did not store write");

	AST_USER_WRITE: assert property (
		(cop_wr_en && cop_reg_num == `CCR_REG_NUM && cop_sel == `CCR_SEL_PRIMARY)
		|=> user_seg_cacheability == $past(cop_wdata[`CCR_USER_LSB +: 3]))
		else $error("user cacheability did not store write");

	AST_KSEG0_READBACK: assert property (
		(cop_wr_en && !cop_rd_en && cop_reg_num == `CCR_REG_NUM && cop_sel == `CCR_SEL_PRIMARY)
		##1 rd_pri |=> cop_rdata[`CCR_KSEG0_LSB +: 3] == $past(cop_wdata[`CCR_KSEG0_LSB +: 3], 2))
		else $error("kernel segment 0 coherency readback wrong");

	AST_RSVD_ZERO: assert property (
		rd_pri |=> (cop_rdata & `CCR_PRI_RSVD_MASK) == 32'h00000000)
		else $error("reserved primary bits not zero");

	AST_RSVD_FLAG: assert property (
		(cop_wr_en && cop_reg_num == `CCR_REG_NUM && cop_sel == `CCR_SEL_PRIMARY
		 && (cop_wdata & `CCR_PRI_RSVD_MASK) != 32'h00000000) |=> reserved_wr_error)
		else $error("nonzero reserved write not flagged");

	AST_CUSTOM_ZERO: assert property (
		s_rd_pri |-> !cop_rdata[`CCR_BIT_CUSTOM])
		else $error("custom instruction bit set");

	AST_SBE_ONE: assert property (
		rd_pri ##1 1'b1 |-> cop_rdata[`CCR_BIT_SBE])
		else $error("simple byte enable bit clear");

	AST_MDU_ZERO: assert property (
		rd_pri |=> cop_rdata[`CCR_BIT_MDU] == 1'b0)
		else $error("multiply/divide bit set");

	AST_DSRAM_ONE: assert property (
		rd_pri |=> cop_rdata[`CCR_BIT_DSRAM] == 1'b1)
		else $error("dual sram bit clear");

	AST_ARCH_FIELDS: assert property (
		rd_pri |=> !cop_rdata[`CCR_BIT_ENDIAN] && cop_rdata[`CCR_AT_LSB +: 2] == `CCR_AT_VAL
		&& cop_rdata[`CCR_AR_LSB +: 3] == `CCR_AR_VAL)
		else $error("endian, arch type or revision wrong");

	AST_MMU_FIXED: assert property (
		rd_pri |=> cop_rdata[`CCR_MT_LSB +: 3] == `CCR_MT_VAL)
		else $error("memory management type not 011");

	AST_SEC_UPPER: assert property (
		rd_sec |=> cop_rdata[31] && cop_rdata[30:5] == 26'h0)
		else $error("secondary upper bits wrong");

	AST_SEC_PERF: assert property (
		rd_sec |=> cop_rdata[`CCR_BIT_PERF])
		else $error("perf counter bit clear");

	AST_SEC_DEBUG: assert property (
		rd_sec |=> cop_rdata[`CCR_BIT_DEBUG])
		else $error("debug extension bit clear");

	AST_SEC_ABSENT: assert property (
		rd_sec |=> !cop_rdata[`CCR_BIT_WATCH] && !cop_rdata[`CCR_BIT_COMPRESS] && !cop_rdata[`CCR_BIT_FLOAT])
		else $error("absent feature bit set in secondary word");

	AST_WRITE_IGNORED: assert property (
		(cop_wr_en && !(cop_reg_num == `CCR_REG_NUM && cop_sel == `CCR_SEL_PRIMARY))
		|=> wr_ignored && $stable(upper_kseg_cacheability) && $stable(user_seg_cacheability)
		&& $stable(kernel_seg0_coherency))
		else $error("write outside primary word changed state");

	AST_FIELDS_HOLD: assert property (
		(!cop_wr_en) [*2] |-> $stable(upper_kseg_cacheability) && $stable(kernel_seg0_coherency)
		&& $stable(user_seg_cacheability))
		else $error("cacheability changed without a write");

	AST_WRITE_HIT: assert property (
		(cop_wr_en && !cop_rd_en)
		|=> cop_hit == ($past(cop_reg_num) == `CCR_REG_NUM && $past(cop_sel) <= `CCR_SEL_SECONDARY))
		else $error("write hit does not match register 16 select 0 or 1");

	AST_UNMAPPED_ZERO: assert property (
		(cop_rd_en && !rd_pri && !rd_sec) |=> cop_rdata == 32'h00000000 && !cop_hit)
		else $error("unmapped read not zero or flagged as hit");

	AST_RSVD_NO_FLAG: assert property (
		!(cop_wr_en && cop_reg_num == `CCR_REG_NUM && cop_sel == `CCR_SEL_PRIMARY
		 && (cop_wdata & `CCR_PRI_RSVD_MASK) != 32'h00000000) |=> !reserved_wr_error)
		else $error("reserved write flag without a reserved write");

	AST_KSEG0_WRITE: assert property (
		(cop_wr_en && cop_reg_num == `CCR_REG_NUM && cop_sel == `CCR_SEL_PRIMARY)
		|=> kernel_seg0_coherency == $past(cop_wdata[`CCR_KSEG0_LSB +: 3]))
		else $error("kernel segment 0 coherency did not store write");

	AST_IGNORED_ONLY: assert property (
		!(cop_wr_en && !(cop_reg_num == `CCR_REG_NUM && cop_sel == `CCR_SEL_PRIMARY))
		|=> !wr_ignored)
		else $error("ignored-write pulse without an ignored write");

	AST_PRI_FIXED: assert property (
		rd_pri |=> (cop_rdata & `CCR_PRI_FIXED_MASK) == `CCR_PRI_FIXED_VAL)
		else $error("fixed primary fields changed");

	AST_SEC_WORD: assert property (
		rd_sec |=> cop_rdata == `CCR_SEC_WORD)
		else $error("secondary word changed");

	AST_CCA_RESET: assert property (
		$rose(resetn) |-> upper_kseg_cacheability == `CCR_CCA_RESET
		&& user_seg_cacheability == `CCR_CCA_RESET && kernel_seg0_coherency == `CCR_CCA_RESET)
		else $error("cacheability fields not at reset value after release");

	AST_RD_PULSE: assert property (
		!cop_rd_en |=> !cop_rd_valid && $stable(cop_rdata))
		else $error("read response without a read");

	COV_RD_PRI: cover property (rd_pri ##1 cop_rd_valid && cop_hit);
	COV_RD_SEC: cover property (rd_sec ##1 cop_rd_valid && cop_hit);
	COV_WR_THEN_RD: cover property (pri_wr ##1 rd_pri ##1 cop_rd_valid);
	COV_WR_IGNORED: cover property (cop_wr_en ##1 wr_ignored);
	COV_RSVD_FLAG: cover property (pri_wr ##1 reserved_wr_error);

endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the core configuration register bank
`timescale 1ns/1ns

module tb_top;
	import ccr_pkg::*;

	// ----------
	// signals and expected-result notes
	// ----------
	typedef struct {
		logic        rd;
		logic [31:0] rdata;
		logic        hit;
		logic        wign;
		logic        rerr;
		ccr_cca_t    up;
		ccr_cca_t    us;
		ccr_cca_t    k0;
	} ccr_note_t;

	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [4:0]  cop_reg_num = 5'h00;
	logic [2:0]  cop_sel = 3'h0;
	logic        cop_rd_en = 1'b0;
	logic        cop_wr_en = 1'b0;
	logic [31:0] cop_wdata = 32'h00000000;
	logic [31:0] cop_rdata;
	logic        cop_rd_valid;
	logic        cop_hit;
	logic        wr_ignored;
	logic        reserved_wr_error;
	ccr_cca_t    upper_kseg_cacheability;
	ccr_cca_t    user_seg_cacheability;
	ccr_cca_t    kernel_seg0_coherency;
	ccr_note_t   notes[$];
	ccr_cca_t    m_up = 3'h2;
	ccr_cca_t    m_us = 3'h2;
	ccr_cca_t    m_k0 = 3'h2;
	logic [31:0] m_rd = 32'h00000000;
	int          bad_count = 0;
	int          checks_done = 0;
	logic [31:0] seed = 32'h0000004A;

	always #25 sys_clk = ~sys_clk;

	ccr_core_config DUT
	(
		.sys_clk                 (sys_clk),
		.resetn                  (resetn),
		.cop_reg_num             (cop_reg_num),
		.cop_sel                 (cop_sel),
		.cop_rd_en               (cop_rd_en),
		.cop_wr_en               (cop_wr_en),
		.cop_wdata               (cop_wdata),
		.cop_rdata               (cop_rdata),
		.cop_rd_valid            (cop_rd_valid),
		.cop_hit                 (cop_hit),
		.wr_ignored              (wr_ignored),
		.reserved_wr_error       (reserved_wr_error),
		.upper_kseg_cacheability (upper_kseg_cacheability),
		.user_seg_cacheability   (user_seg_cacheability),
		.kernel_seg0_coherency   (kernel_seg0_coherency)
	);

	// ----------
	// helpers
	// ----------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// worked out from the field map; unmapped places read zero
	function automatic logic [31:0] exp_word(input logic [4:0] num, input logic [2:0] sel);
		if (num != 5'h10 || sel > 3'h1)
			return 32'h00000000;
		if (sel == 3'h1)
			return 32'h80000012;
		return {1'b1, m_up, m_us, 9'h021, 3'h0, 3'h1, 3'h3, 4'h0, m_k0};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one access; the note holds the read as seen before a same-cycle write
	task automatic acc(input logic rd, input logic wr, input logic [4:0] num, input logic [2:0] sel,
		input logic [31:0] wd);
		ccr_note_t n;
		logic      map;
		@(negedge sys_clk);
		cop_rd_en = rd;
		cop_wr_en = wr;
		cop_reg_num = num;
		cop_sel = sel;
		cop_wdata = wd;
		map = (num == 5'h10) && (sel <= 3'h1);
		n.rd = rd;
		if (rd)
			m_rd = exp_word(num, sel);
		n.rdata = m_rd;
		n.hit = map;
		n.wign = wr && !(map && sel == 3'h0);
		n.rerr = wr && map && sel == 3'h0 && (|(wd & 32'h018E0078));
		if (wr && map && sel == 3'h0)
		begin
			m_up = wd[30:28];
			m_us = wd[27:25];
			m_k0 = wd[2:0];
		end
		n.up = m_up;
		n.us = m_us;
		n.k0 = m_k0;
		notes.push_back(n);
	endtask

	task automatic idle();
		@(negedge sys_clk);
		cop_rd_en = 1'b0;
		cop_wr_en = 1'b0;
	endtask

	// ----------
	// result watcher
	// ----------
	initial
	begin : watch_out
		ccr_note_t n;
		forever
		begin
			@(posedge sys_clk);
			#1;
			if (resetn === 1'b1 && (cop_rd_valid | cop_hit | wr_ignored | reserved_wr_error) !== 1'b0)
			begin
				if (notes.size() == 0)
					chk(32'h1, 32'h0, "result with no request");
				else
				begin
					n = notes.pop_front();
					chk(cop_rd_valid, n.rd, "rd_valid");
					chk(cop_rdata, n.rdata, "rdata");
					chk(cop_hit, n.hit, "hit");
					chk(wr_ignored, n.wign, "wr_ignored");
					chk(reserved_wr_error, n.rerr, "reserved_wr_error");
					chk({upper_kseg_cacheability, user_seg_cacheability, kernel_seg0_coherency},
						{n.up, n.us, n.k0}, "fields");
				end
			end
		end
	end

	initial
	begin : watchdog
		#(50 * 3000);
		bad_count++;
		$display("[ERR] %0t run did not finish", $time);
		report_and_stop();
	end

	// ----------
	// scenarios
	// ----------
	initial
	begin : main
		logic [31:0] r;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		chk(upper_kseg_cacheability, 3'h2, "upper reset");
		chk(user_seg_cacheability, 3'h2, "user reset");
		chk(kernel_seg0_coherency, 3'h2, "kseg0 reset");
		resetn = 1'b1;
		acc(1'b1, 1'b0, 5'h10, 3'h0, 32'h0);
		acc(1'b1, 1'b0, 5'h10, 3'h1, 32'h0);
		acc(1'b0, 1'b1, 5'h10, 3'h0, 32'hFFFFFFFF);
		acc(1'b1, 1'b0, 5'h10, 3'h0, 32'h0);
		acc(1'b0, 1'b1, 5'h10, 3'h1, 32'hFFFFFFFF);
		acc(1'b1, 1'b0, 5'h10, 3'h1, 32'h0);
		acc(1'b1, 1'b1, 5'h10, 3'h0, 32'h018E0078);
		acc(1'b1, 1'b0, 5'h10, 3'h0, 32'h0);
		for (int i = 0; i < 24; i++)
			acc(1'b1, i[0], 5'(15 + i / 8), 3'(i % 8), 32'hFFFFFFFF);
		for (int v = 0; v < 8; v++)
		begin
			acc(1'b0, 1'b1, 5'h10, 3'h0, {1'b0, 3'(v), 3'(7 - v), 22'h0, 3'(v)});
			acc(1'b1, 1'b0, 5'h10, 3'h0, 32'h0);
		end
		repeat (60)
		begin
			r = xs();
			acc(r[0] | ~r[1], r[1], r[2] ? 5'h10 : r[8:4], r[2] ? {2'b00, r[3]} : r[14:12], xs());
		end
		idle();
		@(negedge sys_clk);
		resetn = 1'b0;
		m_up = 3'h2;
		m_us = 3'h2;
		m_k0 = 3'h2;
		m_rd = 32'h00000000;
		@(negedge sys_clk);
		chk({upper_kseg_cacheability, user_seg_cacheability, kernel_seg0_coherency}, 9'h092,
			"fields in reset");
		chk(cop_rd_valid, 1'b0, "rd_valid in reset");
		resetn = 1'b1;
		acc(1'b1, 1'b0, 5'h10, 3'h0, 32'h0);
		acc(1'b1, 1'b0, 5'h10, 3'h1, 32'h0);
		idle();
		idle();
		chk(notes.size(), 0, "results missing");
		report_and_stop();
	end

endmodule
